// ===== shared/pgc_pkg.sv
// Package for the port group register block.
// Assumes one system clock and an APB3 register slave.
package pgc_pkg;

   // ----------------------------------------------------------------------
   // Register map (word index within a group, byte = group base + 4*index)
   // ----------------------------------------------------------------------
   localparam logic [11:0] GROUP_STRIDE  = 12'h040;
   localparam logic [3:0]  REG_DATA      = 4'h0;
   localparam logic [3:0]  REG_ENABLE    = 4'h1;
   localparam logic [3:0]  REG_PULL      = 4'h2;
   localparam logic [3:0]  REG_IRQ_FLAGS = 4'h3;
   localparam logic [3:0]  REG_IRQ_CTRL  = 4'h4;
   localparam logic [3:0]  REG_DEBOUNCE  = 4'h5;
   localparam logic [3:0]  REG_MODE_SEL  = 4'h6;
   localparam logic [3:0]  REG_FUNC_SEL  = 4'h7;
   localparam logic [11:0] ADDR_SUMMARY  = 12'h200;

   // ----------------------------------------------------------------------
   // Groups and widths
   // ----------------------------------------------------------------------
   localparam int NUM_GROUPS  = 6;
   localparam int GROUP_BITS  = 3;
   localparam int PINS        = 8;
   localparam int G4_IDX      = 4;
   localparam int DBG_IDX     = 5;
   localparam int IRQ_GROUPS  = 5;
   localparam int OUT_HI      = 8;

   // Valid pin masks per group
   localparam logic [7:0] MASK_FULL  = 8'hFF;
   localparam logic [7:0] MASK_FIVE  = 8'h1F;
   localparam logic [7:0] MASK_DBG   = 8'h1B;
   localparam logic [7:0] DBG_OUT_MASK = 8'h1F;

   // Reset values
   localparam logic [7:0]  RST_ZERO   = 8'h00;
   localparam logic [7:0]  RST_DBG_MODE = 8'h07;
   localparam logic [15:0] RST_FUNC   = 16'h0000;

   // Function codes
   localparam logic [1:0] FUNC_ROUTER = 2'h1;

   typedef struct packed {
      logic [7:0] out_val;
      logic [7:0] in_en;
      logic [7:0] out_en;
      logic [7:0] pull_dir;
      logic [7:0] pull_en;
      logic [7:0] edge_sel;
      logic [7:0] irq_en;
      logic [7:0] debounce;
      logic [7:0] mode;
      logic [15:0] func;
   } pgc_cfg_t;

endpackage : pgc_pkg

// ===== design/pgc_port_groups.sv
// Port group register block: six pin groups with data, enables, pulls,
// mode and function selection behind an APB3 slave; groups 0 to 4 add edge interrupts.
// Assumes pad cells resolve output, enable and pull signals externally.
`timescale 1ns/1ns

// Overview of operation
// - Summary bit per group 0 to 4 reads 1 while any flag of the group is set.
// - Groups 0 to 3 each have eight pins with I/O and interrupts.
// - Group 4 has five pins; unused upper bits of each byte read zero.
// - Debug group pins 0 to 2 reset into peripheral function mode.
// - Debug pin 2 is output only and has no pull control.
// - Interrupt flags reset to 0; writing 1 clears, writing 0 keeps.
// - Mode 0 selects GPIO; mode 1 routes the 2-bit selected function.
// - Function 1 maps groups 0 to 3 to the router; group 4 has none.
// - Data register: output data high byte, read-only input low byte.
// - Enable register: input enables high byte, output enables low byte.
// - Pull register: pull direction high byte, pull enables low byte.
// - Interrupt control: edge select high byte, enables low byte.
// - Debounce enables in low byte; high byte reads zero.
// - Mode bits in low byte reset to GPIO except debug pins 0 to 2; high byte reads zero.
// - Debug data: output 12-8, input 4-3 and 1-0, bit 2 reserved.
// - Edge bit 1 flags falling edges, 0 flags rising edges.
// - Input data reads 0 while the pin's input enable is 0.
// - Pull applies only while the pin's output enable is 0.
// - In peripheral mode GPIO settings and input data are ignored.
module pgc_port_groups #(
   parameter int NG = pgc_pkg::NUM_GROUPS
)(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             resetn,
   // APB slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic                  pready,
   output logic [31:0]           prdata,
   output logic                  pslverr,
   // Pads
   input  wire logic [NG*8-1:0]  pad_in,
   output logic [NG*8-1:0]       pad_out,
   output logic [NG*8-1:0]       pad_oe_n,
   output logic [NG*8-1:0]       pad_pull_en,
   output logic [NG*8-1:0]       pad_pull_up,
   // Peripheral functions, 4 per pin
   input  wire logic [NG*32-1:0] func_out,
   input  wire logic [NG*32-1:0] func_oe,
   output logic [NG*32-1:0]      func_in,
   // Router function 1 path
   input  wire logic [NG*8-1:0]  router_out,
   input  wire logic [NG*8-1:0]  router_oe,
   output logic [NG*8-1:0]       router_in,
   // Status
   output logic [NG*8-1:0]       debounce_en,
   output logic [4:0]            group_irq_summary
);

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   localparam int GROUP_BITS_W = pgc_pkg::GROUP_BITS - 1;
   logic                  access;
   logic                  wr;
   logic [GROUP_BITS_W:0] grp_sel;
   logic [3:0]            reg_sel;
   logic                  in_groups;
   logic                  hit_sum;
   logic                  mapped;

   assign access    = psel && penable;
   assign wr        = access && pwrite;
   assign grp_sel   = paddr[8:6];
   assign reg_sel   = paddr[5:2];
   assign in_groups = (paddr[11:9] == 3'h0) && (int'(grp_sel) < NG)
                      && (paddr[1:0] == 2'h0) && (reg_sel[3] == 1'b0);
   assign hit_sum   = (paddr == pgc_pkg::ADDR_SUMMARY);
   assign mapped    = in_groups || hit_sum;
   // Zero-wait slave: answer in the first access cycle
   assign pready    = 1'b1;
   assign pslverr   = access && !mapped;

   // ----------------------------------------------------------------------
   // Per-group state
   // ----------------------------------------------------------------------
   pgc_pkg::pgc_cfg_t cfg [NG];
   logic [7:0] in_sync1 [NG];
   logic [7:0] in_sync2 [NG];
   logic [7:0] in_prev  [NG];
   logic [7:0] irq_flag [NG];
   logic [7:0] in_val   [NG];
   logic [15:0] rd_word [NG];

   genvar g;
   generate
      for (g = 0; g < NG; g++)
      begin : gen_group
         localparam logic [7:0] VMASK =
            (g == pgc_pkg::DBG_IDX) ? pgc_pkg::MASK_DBG :
            (g == pgc_pkg::G4_IDX)  ? pgc_pkg::MASK_FIVE :
                                      pgc_pkg::MASK_FULL;
         // Output and enable fields: debug bit 2 still has an output
         localparam logic [7:0] OMASK =
            (g == pgc_pkg::DBG_IDX) ? pgc_pkg::DBG_OUT_MASK : VMASK;
         localparam logic [7:0] IMASK =
            (g == pgc_pkg::DBG_IDX) ? 8'h00 : VMASK;
         localparam logic [7:0] MODE_RST =
            (g == pgc_pkg::DBG_IDX) ? pgc_pkg::RST_DBG_MODE
                                    : pgc_pkg::RST_ZERO;
         localparam logic [15:0] FMASK =
            (g == pgc_pkg::G4_IDX || g == pgc_pkg::DBG_IDX)
            ? 16'h03FF : 16'hFFFF;
         localparam logic [7:0] FMSK =
            (g == pgc_pkg::DBG_IDX) ? pgc_pkg::DBG_OUT_MASK : VMASK;
         logic                hit;
         logic [7:0]          hi;
         logic [7:0]          lo;
         logic [7:0]          rise_fall;
         logic [7:0]          clr;

         assign hit = wr && in_groups && (int'(grp_sel) == g);
         assign hi  = pwdata[15:8];
         assign lo  = pwdata[7:0];

         // Configuration registers; reserved bits masked on write
         always_ff @(posedge clock)
         begin
            if (!resetn)
            begin
               cfg[g]      <= '0;
               cfg[g].mode <= MODE_RST;
               cfg[g].func <= pgc_pkg::RST_FUNC;
            end
            else if (hit)
            begin
               unique case (reg_sel)
                  pgc_pkg::REG_DATA:
                     cfg[g].out_val <= hi & OMASK;
                  pgc_pkg::REG_ENABLE:
                  begin
                     cfg[g].in_en  <= hi & VMASK;
                     cfg[g].out_en <= lo & OMASK;
                  end
                  pgc_pkg::REG_PULL:
                  begin
                     cfg[g].pull_dir <= hi & VMASK;
                     cfg[g].pull_en  <= lo & VMASK;
                  end
                  pgc_pkg::REG_IRQ_CTRL:
                  begin
                     cfg[g].edge_sel <= hi & IMASK;
                     cfg[g].irq_en   <= lo & IMASK;
                  end
                  pgc_pkg::REG_DEBOUNCE:
                     cfg[g].debounce <= lo & IMASK;
                  pgc_pkg::REG_MODE_SEL:
                     cfg[g].mode <= lo & FMSK;
                  pgc_pkg::REG_FUNC_SEL:
                     cfg[g].func <= pwdata[15:0] & FMASK;
                  default:
                     cfg[g].func <= cfg[g].func;
               endcase
            end
         end

         // Two-flop synchroniser; stage two and its delayed copy in_prev feed logic
         always_ff @(posedge clock)
         begin
            if (!resetn)
            begin
               in_sync1[g] <= '0;
               in_sync2[g] <= '0;
               in_prev[g]  <= '0;
            end
            else
            begin
               in_sync1[g] <= pad_in[g*8 +: 8];
               in_sync2[g] <= in_sync1[g];
               in_prev[g]  <= in_sync2[g];
            end
         end

         // Input read value: gated by enable and GPIO mode
         assign in_val[g] = in_sync2[g] & cfg[g].in_en & ~cfg[g].mode
                            & VMASK;

         // Edge select: 1 falling, 0 rising
         assign rise_fall = IMASK & cfg[g].irq_en & ~cfg[g].mode &
            ((cfg[g].edge_sel & in_prev[g] & ~in_sync2[g] & cfg[g].in_en)
            | (~cfg[g].edge_sel & ~in_prev[g] & in_sync2[g]
               & cfg[g].in_en));
         assign clr = (hit && reg_sel == pgc_pkg::REG_IRQ_FLAGS)
                      ? lo : 8'h00;

         // Set wins over a simultaneous clear
         always_ff @(posedge clock)
         begin
            if (!resetn)
               irq_flag[g] <= '0;
            else
               irq_flag[g] <= ((irq_flag[g] & ~clr) | rise_fall)
                              & IMASK;
         end

         always_comb
         begin
            unique case (reg_sel)
               pgc_pkg::REG_DATA:
                  rd_word[g] = {cfg[g].out_val, in_val[g]};
               pgc_pkg::REG_ENABLE:
                  rd_word[g] = {cfg[g].in_en, cfg[g].out_en};
               pgc_pkg::REG_PULL:
                  rd_word[g] = {cfg[g].pull_dir, cfg[g].pull_en};
               pgc_pkg::REG_IRQ_FLAGS:
                  rd_word[g] = {8'h00, irq_flag[g]};
               pgc_pkg::REG_IRQ_CTRL:
                  rd_word[g] = {cfg[g].edge_sel, cfg[g].irq_en};
               pgc_pkg::REG_DEBOUNCE:
                  rd_word[g] = {8'h00, cfg[g].debounce};
               pgc_pkg::REG_MODE_SEL:
                  rd_word[g] = {8'h00, cfg[g].mode};
               pgc_pkg::REG_FUNC_SEL:
                  rd_word[g] = cfg[g].func;
               default:
                  rd_word[g] = 16'h0000;
            endcase
         end

         // ---------------------------------------------------------------
         // Pin multiplexer
         // ---------------------------------------------------------------
         genvar p;
         for (p = 0; p < pgc_pkg::PINS; p++)
         begin : gen_pin
            localparam int PI = g*8 + p;
            logic [1:0] fsel;
            logic       use_router;
            logic       no_func;
            logic       f_out;
            logic       f_oe;
            assign fsel = cfg[g].func[2*p +: 2];
            // Group 4 and debug have no router slot
            assign use_router = (g < pgc_pkg::G4_IDX)
                                && (fsel == pgc_pkg::FUNC_ROUTER);
            // Group 4 function 1 is unassigned: pin floats
            assign no_func = (g == pgc_pkg::G4_IDX)
                             && (fsel == pgc_pkg::FUNC_ROUTER);
            assign f_out = no_func    ? 1'b0 :
                           use_router ? router_out[PI]
                                      : func_out[PI*4 + int'(fsel)];
            assign f_oe  = no_func    ? 1'b0 :
                           use_router ? router_oe[PI]
                                      : func_oe[PI*4 + int'(fsel)];

            always_comb
            begin
               if (!OMASK[p])
               begin
                  pad_out[PI]     = 1'b0;
                  pad_oe_n[PI]    = 1'b1;
                  pad_pull_en[PI] = 1'b0;
                  pad_pull_up[PI] = 1'b0;
               end
               else if (cfg[g].mode[p])
               begin
                  pad_out[PI]     = f_out;
                  pad_oe_n[PI]    = ~f_oe;
                  pad_pull_en[PI] = 1'b0;
                  pad_pull_up[PI] = 1'b0;
               end
               else
               begin
                  pad_out[PI]     = cfg[g].out_val[p];
                  pad_oe_n[PI]    = ~cfg[g].out_en[p];
                  pad_pull_en[PI] = cfg[g].pull_en[p]
                                    & ~cfg[g].out_en[p];
                  pad_pull_up[PI] = cfg[g].pull_dir[p];
               end
            end

            // Peripheral inputs only see the pin in its selected slot
            for (genvar f = 0; f < 4; f++)
            begin : gen_fin
               assign func_in[PI*4 + f] = VMASK[p] && cfg[g].mode[p]
                  && (fsel == 2'(f)) && !(use_router)
                  && in_sync2[g][p];
            end
            assign router_in[PI] = use_router && cfg[g].mode[p]
                                   && in_sync2[g][p];
         end

         assign debounce_en[g*8 +: 8] = cfg[g].debounce;
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Group summary and read data
   // ----------------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < pgc_pkg::IRQ_GROUPS; i++)
         group_irq_summary[i] = |irq_flag[i];
   end

   always_comb
   begin
      prdata = 32'h0000_0000;
      if (access && !pwrite)
      begin
         if (hit_sum)
            prdata = {27'h0, group_irq_summary};
         else if (in_groups)
            prdata = {16'h0000, rd_word[grp_sel]};
      end
   end

endmodule : pgc_port_groups

// ===== verification/pgc_port_groups_chk.sv
// Concurrent checks on the port group block, bound to its top module.
// Assumes the package is compiled first and one clock domain.
`timescale 1ns/1ns
module pgc_port_groups_chk #(
   parameter int NG = pgc_pkg::NUM_GROUPS
)(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             resetn,
   // APB
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      prdata,
   input  wire logic             pslverr,
   // Pins and status
   input  wire logic [NG*8-1:0]  pad_in,
   input  wire logic [NG*8-1:0]  pad_oe_n,
   input  wire logic [NG*8-1:0]  pad_pull_en,
   input  wire logic [NG*32-1:0] func_oe,
   input  wire logic [4:0]       group_irq_summary
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   property p_clr_rst;
      $past(!resetn) |-> group_irq_summary == 5'h00;
   endproperty
   a_clr_rst: assert property (p_clr_rst) else $error("flags set");
   property p_oe_rst;
      $past(!resetn) |-> pad_oe_n[39:0] == 40'hFF_FFFF_FFFF;
   endproperty
   a_oe_rst: assert property (p_oe_rst) else $error("pin driven");
   property p_dbg_rst;
      $past(!resetn) |-> pad_oe_n[40] == !func_oe[160];
   endproperty
   a_dbg_rst: assert property (p_dbg_rst) else $error("dbg pin");
   property p_sum_rd;
      psel && penable && !pwrite && paddr == pgc_pkg::ADDR_SUMMARY
         |-> prdata == {27'h0000000, group_irq_summary};
   endproperty
   a_sum_rd: assert property (p_sum_rd) else $error("summary");
   property p_unmap;
      psel && penable && paddr > 12'h200 |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped");
   property p_pull;
      (pad_pull_en & ~pad_oe_n) == '0;
   endproperty
   a_pull: assert property (p_pull) else $error("pull on driven");
   property p_pin2;
      pad_pull_en[42] == 1'b0;
   endproperty
   a_pin2: assert property (p_pin2) else $error("pin2 pull");
   property p_g4;
      &pad_oe_n[39:37] && pad_pull_en[39:37] == 3'h0;
   endproperty
   a_g4: assert property (p_g4) else $error("g4 spare pin");
   property p_edge;
      $rose(group_irq_summary[2])
         |-> $past(pad_in[23:16], 2) != $past(pad_in[23:16], 6);
   endproperty
   a_edge: assert property (p_edge) else $error("flag no edge");
   c_sum: cover property ($rose(group_irq_summary[2]));
   c_err: cover property (psel && penable && pslverr);
   c_clr: cover property (psel && penable && pwrite && paddr == 12'h08C);
endmodule : pgc_port_groups_chk
// ---------------------------------------------------------------------
// Bind
// ---------------------------------------------------------------------
bind pgc_port_groups pgc_port_groups_chk #(.NG(NG)) u_chk (
   .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
   .pad_in(pad_in), .pad_oe_n(pad_oe_n), .pad_pull_en(pad_pull_en),
   .func_oe(func_oe), .group_irq_summary(group_irq_summary)
);

// ===== verification/pgc_pin_model.sv
// Pin model: resolves each pad from device drive, bench drive and pulls.
// Assumes the bench gives external levels with their drive enables.
`timescale 1ns/1ns
module pgc_pin_model #(
   parameter int N = 48
)(
   // Clock
   input  wire logic         clock,
   // Device side
   input  wire logic [N-1:0] pad_out,
   input  wire logic [N-1:0] pad_oe_n,
   input  wire logic [N-1:0] pad_pull_en,
   input  wire logic [N-1:0] pad_pull_up,
   // Bench side
   input  wire logic [N-1:0] ext_lvl,
   input  wire logic [N-1:0] ext_drv,
   // Resolved level
   output logic      [N-1:0] pad_in
);
   logic [N-1:0] flt = '0;
   // Floating pins toggle so a stale level never passes for a real one
   always_ff @(posedge clock)
   begin
      flt <= ~flt;
   end
   // Device drive wins; a pull acts only on an undriven pin
   assign pad_in = (~pad_oe_n & pad_out)
      | (pad_oe_n & ext_drv & ext_lvl)
      | (pad_oe_n & ~ext_drv & pad_pull_en & pad_pull_up)
      | (pad_oe_n & ~ext_drv & ~pad_pull_en & flt);
endmodule : pgc_pin_model

// ===== verification/pgc_port_groups_test.sv
// Self-checking bench for the port group block over APB.
// Assumes package, pin model and checker are compiled before it.
`timescale 1ns/1ns
module pgc_port_groups_test;
   // ------------------------------------------------------------------
   // Table and signals
   // ------------------------------------------------------------------
   typedef struct packed {
      logic        w;
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] x;
      logic        e;
   } pgc_row_t;
   localparam logic [191:0] FUNC_OUT   = {48{4'h5}};
   localparam logic [191:0] FUNC_OE    = {48{4'hA}};
   localparam logic [47:0]  ROUTER_OUT = 48'h0000_0000_00C3;
   localparam logic [47:0]  ROUTER_OE  = 48'hFFFF_FFFF_FFF0;
   pgc_row_t rows [16] = '{
      '{1'b0, 12'h000, 32'h0, 32'h00000000, 1'b0},
      '{1'b0, 12'h158, 32'h0, 32'h00000007, 1'b0},
      '{1'b0, 12'h200, 32'h0, 32'h00000000, 1'b0},
      '{1'b1, 12'h004, 32'hFFFFFFFF, 32'h0000FFFF, 1'b0},
      '{1'b1, 12'h014, 32'hFFFF, 32'h000000FF, 1'b0},
      '{1'b1, 12'h104, 32'hFFFF, 32'h00001F1F, 1'b0},
      '{1'b1, 12'h11C, 32'hFFFF, 32'h000003FF, 1'b0},
      '{1'b1, 12'h10C, 32'hFFFF, 32'h00000000, 1'b0},
      '{1'b1, 12'h140, 32'hFFFF, 32'h00001F00, 1'b0},
      '{1'b1, 12'h148, 32'hFFFF, 32'h00001B1B, 1'b0},
      '{1'b1, 12'h0C8, 32'hFFFF, 32'h0000FFFF, 1'b0},
      '{1'b1, 12'h084, 32'hFF00, 32'h0000FF00, 1'b0},
      '{1'b1, 12'h090, 32'h0FFF, 32'h00000FFF, 1'b0},
      '{1'b1, 12'h05C, 32'h1234, 32'h00001234, 1'b0},
      '{1'b1, 12'h058, 32'hFFFF, 32'h000000FF, 1'b0},
      '{1'b1, 12'h300, 32'hFFFF, 32'h00000000, 1'b1}
   };
   logic         clock, resetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, prdata, rdata, v;
   logic [47:0]  pad_in, pad_out, pad_oe_n, pad_pull_en, pad_pull_up;
   logic [47:0]  ext_lvl, ext_drv, debounce_en;
   logic [4:0]   group_irq_summary;
   int           errors = 0;
   int           checks_done = 0;
   int           cycles = 0;
   pgc_port_groups dut (
      .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_en(pad_pull_en),
      .pad_pull_up(pad_pull_up), .func_out(FUNC_OUT), .func_oe(FUNC_OE),
      .func_in(), .router_out(ROUTER_OUT), .router_oe(ROUTER_OE),
      .router_in(), .debounce_en(debounce_en),
      .group_irq_summary(group_irq_summary)
   );
   pgc_pin_model pins (
      .clock(clock), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .pad_pull_en(pad_pull_en), .pad_pull_up(pad_pull_up),
      .ext_lvl(ext_lvl), .ext_drv(ext_drv), .pad_in(pad_in)
   );
   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
         errors = errors + 1;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   // Holds the request until pready; one idle edge keeps psel clean
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
         @(posedge clock);
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : xfer
   task automatic rd_chk(input string n, input logic [11:0] a,
                         input logic [31:0] x);
      xfer(1'b0, a, 32'h0);
      chk(n, rdata, x);
   endtask : rd_chk
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   // ------------------------------------------------------------------
   // Clock, timeout and sequence
   // ------------------------------------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         errors = errors + 1;
         summarize();
      end
   end
   initial
   begin
      resetn  = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      ext_lvl = 48'h0000_00FF_0000;
      ext_drv = 48'h0000_00FF_0000;
      tick(5);
      resetn <= 1'b1;
      tick(1);
      foreach (rows[i])
      begin
         if (rows[i].w)
            xfer(1'b1, rows[i].a, rows[i].d);
         xfer(1'b0, rows[i].a, 32'h0);
         chk("row data", rdata, rows[i].x);
         chk("row error", {31'h0, rerr}, {31'h0, rows[i].e});
      end
      chk("debounce", {24'h0, debounce_en[7:0]}, 32'h000000FF);
      xfer(1'b1, 12'h000, 32'h00005A00);
      v = {16'h0, pad_out[7:0], pad_oe_n[7:0]};
      chk("gpio out", v, 32'h00005A00);
      tick(3);
      rd_chk("loop", 12'h000, 32'h00005A5A);
      rd_chk("in off", 12'h0C0, 32'h0);
      xfer(1'b1, 12'h0C4, 32'h0000FF00);
      tick(3);
      rd_chk("pull up", 12'h0C0, 32'h000000FF);
      xfer(1'b1, 12'h08C, 32'h000000FF);
      rd_chk("clear", 12'h08C, 32'h0);
      ext_lvl[23:16] <= 8'h00;
      tick(4);
      rd_chk("fall", 12'h08C, 32'h0000000F);
      rd_chk("summary", 12'h200, 32'h00000004);
      ext_lvl[23:16] <= 8'hFF;
      tick(4);
      rd_chk("rise", 12'h08C, 32'h000000FF);
      xfer(1'b1, 12'h08C, 32'h0000000F);
      rd_chk("w1c", 12'h08C, 32'h000000F0);
      xfer(1'b1, 12'h08C, 32'h000000F0);
      rd_chk("summary off", 12'h200, 32'h0);
      xfer(1'b1, 12'h01C, 32'h00005555);
      xfer(1'b1, 12'h018, 32'h000000FF);
      v = {16'h0, pad_out[7:0], pad_oe_n[7:0]};
      chk("router", v, 32'h0000C30F);
      tick(3);
      rd_chk("periph in", 12'h000, 32'h00005A00);
      xfer(1'b1, 12'h11C, 32'h00000155);
      xfer(1'b1, 12'h118, 32'h0000001F);
      chk("g4 no f1", {27'h0, pad_oe_n[36:32]}, 32'h0000001F);
      resetn <= 1'b0;
      tick(2);
      resetn <= 1'b1;
      tick(1);
      rd_chk("reset en", 12'h004, 32'h0);
      rd_chk("reset mode", 12'h158, 32'h00000007);
      summarize();
   end
endmodule : pgc_port_groups_test
